// file: src/iwdt_defs.vh
// Register map, field positions, reset values and timing counts
`ifndef IWDT_DEFS_VH
`define IWDT_DEFS_VH

// =====================================================
// Register offsets (12-bit word address space)
`define IWDT_ADDR_W 12
`define IWDT_OFS_MODE 12'hf85
`define IWDT_OFS_COUNT 12'hf86
`define IWDT_OFS_CTRL 12'hf87
`define IWDT_OFS_MODEBIT 12'hf88

// =====================================================
// Field positions
`define IWDT_RESTART_BIT 3
`define IWDT_CTRL_WDEN 0
`define IWDT_CTRL_IRQ 1
`define IWDT_CTRL_STBY 2
`define IWDT_CTRL_RSTWAIT 3

// =====================================================
// Reset values
`define IWDT_MODE_RST 4'h0
`define IWDT_SEL_RST 3'h0
`define IWDT_CNT_RST 8'h00

// =====================================================
// Clock select codes and prescaler exponents
`define IWDT_SEL_12 3'h0
`define IWDT_SEL_9 3'h3
`define IWDT_SEL_7 3'h5
`define IWDT_SEL_5 3'h7
`define IWDT_EXP_12 4'hc
`define IWDT_EXP_9 4'h9
`define IWDT_EXP_7 4'h7
`define IWDT_EXP_5 4'h5
`define IWDT_PRE_W 12

// =====================================================
// Timing exponents: waits are powers of two of system clock periods
`define IWDT_WAIT_W 21
`define IWDT_CNT_EXP 5'h08
`define IWDT_RC_WAIT_EXP 5'h09
`define IWDT_RST_WAIT_SHORT 5'h0f
`define IWDT_RST_WAIT_LONG 5'h11

`endif

// file: src/iwdt_prescaler.v
// Free-running system clock divider with selectable tick output
`timescale 1ns/10ps
`default_nettype none
`include "iwdt_defs.vh"

module iwdt_prescaler #(
	parameter WIDTH = `IWDT_PRE_W
) (
	// Clock and reset
	input wire clk_i,
	input wire reset_i,
	// Control
	input wire clear_i,
	input wire [3:0] exp_i,
	// Tick out
	output wire tick_o
);

	// =====================================================
	// Divider register
	reg [WIDTH-1:0] div_q; // Running count
	reg [WIDTH-1:0] div_d; // Next count
	reg [WIDTH-1:0] mask; // Low bits that must be all ones

	// Next count, cleared on restart
	always @* begin
		div_d = div_q + {{(WIDTH-1){1'b0}}, 1'b1};
		if (clear_i) begin
			div_d = {WIDTH{1'b0}};
		end
	end

	// Mask for the chosen division
	always @* begin
		mask = ({WIDTH{1'b1}} >> (WIDTH - exp_i));
	end

	// Divider flop
	always @(posedge clk_i) begin
		if (reset_i) begin
			div_q <= {WIDTH{1'b0}};
		end else begin
			div_q <= div_d;
		end
	end

	// One tick every 2^exp clocks
	assign tick_o = !clear_i && ((div_q & mask) == mask);

endmodule
`default_nettype wire

// file: src/iwdt_wait_counter.v
// Oscillation-stabilisation wait counter driven by tick_i, which iwdt_top ties high so it counts system clocks
`timescale 1ns/10ps
`default_nettype none

module iwdt_wait_counter #(
	parameter CW = 8
) (
	// Clock and reset
	input wire clk_i,
	input wire reset_i,
	// Control
	input wire start_i,
	input wire [CW-1:0] target_i,
	input wire tick_i,
	// Status
	output reg busy_o
);

	// =====================================================
	// Wait state
	reg [CW-1:0] cnt_q; // Ticks counted so far
	reg [CW-1:0] tgt_q; // Target held for the whole wait

	// Count ticks until target reached
	always @(posedge clk_i) begin
		if (reset_i) begin
			cnt_q <= {CW{1'b0}};
			tgt_q <= {CW{1'b0}};
			busy_o <= 1'b0;
		end else if (start_i) begin
			// Latch target so later mode changes cannot stretch it
			cnt_q <= {CW{1'b0}};
			tgt_q <= target_i;
			busy_o <= 1'b1;
		end else if (busy_o && tick_i) begin
			if (cnt_q == tgt_q) begin
				busy_o <= 1'b0;
			end
			cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
		end
	end

endmodule
`default_nettype wire

// file: src/iwdt_top.v
// Interval timer / watchdog top level with register port
`timescale 1ns/10ps
`default_nettype none
`include "iwdt_defs.vh"

module iwdt_top #(
	parameter RC_OSC = 1'b0,
	parameter LONG_RESET_WAIT = 1'b0
) (
	// Clock and reset
	input wire clk_i,
	input wire reset_i,
	// Register port
	input wire [`IWDT_ADDR_W-1:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	// Standby release request
	input wire standby_release_i,
	// Events and status
	output reg irq_o,
	output reg wdt_reset_o,
	output reg wait_busy_o
);

	// =====================================================
	// State
	reg [2:0] mode_q; // Clock select bits
	reg restart_q; // Restart bit, self clearing
	reg [7:0] count_q; // Interval counter
	reg wden_q; // Watchdog enable, sticky
	reg irqf_q; // Interrupt request flag
	reg rst_wait_q; // Post-reset wait pending
	reg [3:0] exp_sel; // Prescaler exponent
	reg [4:0] wait_exp; // Wait length in system clocks, as exponent
	reg [`IWDT_WAIT_W-1:0] wait_tgt; // Wait clock count minus one
	reg [7:0] rd_d; // Read mux
	wire tick; // Counter input clock tick
	wire ovf; // Counter overflow this cycle
	wire wr_mode; // Whole-register write
	wire wr_bit; // Single-bit restart write
	wire restart; // Restart command
	wire wait_start; // Begin stabilisation wait
	wire wait_busy; // Wait in progress

	// =====================================================
	// Decoding
	function [3:0] sel_exp;
		input [2:0] sel;
		begin
			case (sel)
				`IWDT_SEL_9: sel_exp = `IWDT_EXP_9;
				`IWDT_SEL_7: sel_exp = `IWDT_EXP_7;
				`IWDT_SEL_5: sel_exp = `IWDT_EXP_5;
				default: sel_exp = `IWDT_EXP_12;
			endcase
		end
	endfunction

	// Division picked by low mode bits; other codes are barred, and decode as 2^12 here
	always @* begin
		exp_sel = sel_exp(mode_q);
	end

	assign wr_mode = wr_i && (addr_i == `IWDT_OFS_MODE);
	assign wr_bit = wr_i && (addr_i == `IWDT_OFS_MODEBIT);
	assign restart = (wr_mode && wdata_i[`IWDT_RESTART_BIT]) ||
		(wr_bit && wdata_i[0]);

	// =====================================================
	// Prescaler
	iwdt_prescaler #(
		.WIDTH(`IWDT_PRE_W)
	) u_pre (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.clear_i(restart),
		.exp_i(exp_sel),
		.tick_o(tick)
	);

	// 256 ticks of 2^n gives 2^(n+8) overflow period
	assign ovf = tick && (count_q == 8'hff);

	// =====================================================
	// Mode register
	always @(posedge clk_i) begin
		if (reset_i) begin
			mode_q <= `IWDT_SEL_RST;
			restart_q <= 1'b0;
		end else begin
			if (wr_mode) begin
				mode_q <= wdata_i[2:0];
			end
			// Bit reads back as one only in the start cycle
			restart_q <= restart;
		end
	end

	// =====================================================
	// Counter, continuous; bus writes to it have no effect
	always @(posedge clk_i) begin
		if (reset_i) begin
			count_q <= `IWDT_CNT_RST;
		end else if (restart) begin
			count_q <= `IWDT_CNT_RST;
		end else if (tick) begin
			count_q <= count_q + 8'h01;
		end
	end

	// =====================================================
	// Flags: restart clear beats overflow set, since restart masks the tick
	always @(posedge clk_i) begin
		if (reset_i) begin
			wden_q <= 1'b0;
			irqf_q <= 1'b0;
		end else begin
			if (wr_i && (addr_i == `IWDT_OFS_CTRL) &&
				wdata_i[`IWDT_CTRL_WDEN]) begin
				wden_q <= 1'b1;
			end
			if (ovf && !wden_q) begin
				irqf_q <= 1'b1;
			end else if (restart) begin
				irqf_q <= 1'b0;
			end
		end
	end

	// =====================================================
	// Stabilisation wait after reset or standby release
	always @(posedge clk_i) begin
		if (reset_i) begin
			rst_wait_q <= 1'b1;
		end else begin
			rst_wait_q <= 1'b0;
		end
	end

	assign wait_start = rst_wait_q || standby_release_i;

	// Wait in system clocks: on crystal a fixed option after reset and
	// the selected interval after standby; always 2^9 clocks on RC
	always @* begin
		if (RC_OSC) begin
			// Fixed wait regardless of mode
			wait_exp = `IWDT_RC_WAIT_EXP;
		end else if (rst_wait_q) begin
			wait_exp = LONG_RESET_WAIT ? `IWDT_RST_WAIT_LONG :
				`IWDT_RST_WAIT_SHORT;
		end else begin
			// One selected overflow interval
			wait_exp = {1'b0, exp_sel} + `IWDT_CNT_EXP;
		end
		wait_tgt = ({{(`IWDT_WAIT_W-1){1'b0}}, 1'b1} << wait_exp) -
			{{(`IWDT_WAIT_W-1){1'b0}}, 1'b1};
	end

	// Wait counted in system clocks, exact for every variant
	iwdt_wait_counter #(
		.CW(`IWDT_WAIT_W)
	) u_wait (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.start_i(wait_start),
		.target_i(wait_tgt),
		.tick_i(1'b1),
		.busy_o(wait_busy)
	);

	// =====================================================
	// Outputs and read port
	always @* begin
		case (addr_i)
			`IWDT_OFS_MODE: rd_d = {4'h0, restart_q, mode_q};
			`IWDT_OFS_COUNT: rd_d = count_q;
			`IWDT_OFS_CTRL: rd_d = {4'h0, rst_wait_q, wait_busy,
				irqf_q, wden_q};
			default: rd_d = 8'h00;
		endcase
	end

	always @(posedge clk_i) begin
		if (reset_i) begin
			rdata_o <= 8'h00;
			irq_o <= 1'b0;
			wdt_reset_o <= 1'b0;
			wait_busy_o <= 1'b0;
		end else begin
			rdata_o <= rd_i ? rd_d : 8'h00;
			irq_o <= irqf_q;
			// Overflow during a stabilisation wait does not reset
			wdt_reset_o <= wden_q && ovf && !wait_busy;
			wait_busy_o <= wait_busy;
		end
	end

endmodule
`default_nettype wire

// file: tb/iwdt_top_props.sv
// Port checker for the interval timer and watchdog
`timescale 1ns/10ps
`default_nettype none
module iwdt_top_props (
	// Clock and reset
	input wire clk_i,
	input wire reset_i,
	// Register port
	input wire [11:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	input wire [7:0] rdata_o,
	// Events and status
	input wire standby_release_i,
	input wire irq_o,
	input wire wdt_reset_o,
	input wire wait_busy_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// =====================================
	// Register port
	property p_rd_idle;
		!rd_i |=> rdata_o == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside its slot");
	property p_rd_mode;
		rd_i && addr_i == 12'hf85 |=> rdata_o[7:4] == 4'h0;
	endproperty
	a_rd_mode: assert property (p_rd_mode)
		else $error("mode reads beyond four bits");
	// =====================================
	// Interrupt flag
	property p_irq_clear;
		wr_i && addr_i == 12'hf85 && wdata_i[3] |-> ##[1:2] !irq_o;
	endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("restart left the flag set");
	property p_irq_hold;
		irq_o && !wr_i && !$past(wr_i) && !$past(wr_i, 2) |=> irq_o;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("flag dropped without restart");
	property p_irq_fell;
		$fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3);
	endproperty
	a_irq_fell: assert property (p_irq_fell)
		else $error("flag fell with no write");
	// =====================================
	// Watchdog and wait
	property p_busy_start;
		standby_release_i |-> ##[1:3] wait_busy_o;
	endproperty
	a_busy_start: assert property (p_busy_start)
		else $error("standby wait did not start");
	property p_wdt_pulse;
		wdt_reset_o |=> !wdt_reset_o;
	endproperty
	a_wdt_pulse: assert property (p_wdt_pulse)
		else $error("watchdog reset wider than one cycle");
	property p_wdt_busy;
		wdt_reset_o |-> !wait_busy_o;
	endproperty
	a_wdt_busy: assert property (p_wdt_busy)
		else $error("watchdog reset during wait");
endmodule
`default_nettype wire

// file: tb/iwdt_top_bench.sv
// Self-checking bench for the interval timer and watchdog
`timescale 1ns/10ps
`default_nettype none
module iwdt_top_bench;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic standby_release_i = 1'b0;
	logic [11:0] addr_i = 12'h000;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] v;
	logic [2:0] codes [4] = '{3'h0, 3'h3, 3'h5, 3'h7};
	wire [7:0] rdata_o;
	wire irq_o, wdt_reset_o, wait_busy_o;
	int mismatches = 0;
	int checks_done = 0;
	int n;
	// Clock at 4 ns
	always #2 clk_i = ~clk_i;
	iwdt_top iwdt_top_i (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.standby_release_i(standby_release_i), .irq_o(irq_o),
		.wdt_reset_o(wdt_reset_o), .wait_busy_o(wait_busy_o));
	// Compare and count
	task automatic chk(input string nm, input logic [7:0] s, e);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// One-cycle write
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	// One-cycle read, data taken in the next cycle
	task automatic rd(input logic [11:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask
	function automatic logic ev(input int w);
		case (w)
			0: ev = irq_o;
			1: ev = wdt_reset_o;
			2: ev = wait_busy_o;
			default: ev = ~wait_busy_o;
		endcase
	endfunction
	// Bounded wait for an event
	task automatic hold(input int w, input int lim);
		n = 0;
		while (ev(w) !== 1'b1 && n < lim) begin
			@(posedge clk_i);
			#1 n++;
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(12'hf85);
		chk("mode", v, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(12'hf85, {5'h00, codes[c]});
			rd(12'hf85);
			chk("select", v, {5'h00, codes[c]});
		end
		wr(12'hf85, 8'h0f);
		rd(12'hf85);
		chk("self clear", v, 8'h07);
		rd(12'hf86);
		chk("count", {7'h00, v > 8'h01}, 8'h00);
		wr(12'hf86, 8'hff);
		rd(12'hf86);
		chk("count ro", {7'h00, v > 8'h01}, 8'h00);
		hold(3, 40000);
		chk("reset wait", {7'h00, wait_busy_o}, 8'h00);
		$display("test registers done");
		wr(12'hf85, 8'h0f);
		repeat (2) @(posedge clk_i);
		#1 chk("irq start", {7'h00, irq_o}, 8'h00);
		hold(0, 8300);
		chk("irq late", {7'h00, n > 8100}, 8'h01);
		chk("irq", {7'h00, irq_o}, 8'h01);
		wr(12'hf88, 8'h01);
		repeat (3) @(posedge clk_i);
		#1 chk("irq clear", {7'h00, irq_o}, 8'h00);
		$display("test interval done");
		@(posedge clk_i);
		standby_release_i <= 1'b1;
		@(posedge clk_i);
		standby_release_i <= 1'b0;
		hold(2, 4);
		chk("wait on", {7'h00, wait_busy_o}, 8'h01);
		hold(3, 8400);
		chk("wait off", {7'h00, wait_busy_o}, 8'h00);
		$display("test standby done");
		wr(12'hf85, 8'h0f);
		wr(12'hf87, 8'h01);
		rd(12'hf87);
		chk("wd flag", v & 8'h01, 8'h01);
		hold(1, 8400);
		chk("wd reset", {7'h00, wdt_reset_o}, 8'h01);
		chk("wd no irq", {7'h00, irq_o}, 8'h00);
		$display("test watchdog done");
		complete_run();
	end
	// Watchdog on the whole run
	initial begin
		#320000;
		mismatches++;
		complete_run();
	end
endmodule
bind iwdt_top iwdt_top_props iwdt_top_props_i (.clk_i(clk_i),
	.reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .standby_release_i(standby_release_i),
	.irq_o(irq_o), .wdt_reset_o(wdt_reset_o), .wait_busy_o(wait_busy_o));
`default_nettype wire
